// file: cimd_core.sv
// interrupt entry/return sequencer with memory space decode
// assumes the core pulses instruction events and owns the stack ram
//
// Behaviour
// - accepted interrupt waits at least five cycles before vector executes.
// - program counter pushed to stack during entry.
// - vector jump adds three cycles to reach handler.
// - multi-cycle instruction completes before entry starts.
// - wake from sleep adds five entry cycles beyond start-up time.
// - return takes five cycles, pops pc, sp plus two, sets enable.
// - sleep right after enabling enters sleep before pending interrupts.
// - registers to 0x001F, i/o to 0x005F, extended i/o to 0x00FF.
// - 0x0100 to 0x20FF selects internal data ram.
// - extended i/o only by load/store; short i/o sees 64 locations.
// - program memory is 64K x 16 words, one or two word instructions.
// - program counter is 16 bits, word addressed.
// - program memory split into boot and application sections.
// - byte constants fetchable from whole program memory.
// - nonvolatile store is linear from zero to 0x0FFF.
// - addresses above internal ram go to external region.
// - external strobes idle during internal data accesses.
// - accepting an interrupt clears global enable.
module cimd_core
    import cimd_pkg::*;
(
    input  wire logic                REF_CLK,
    input  wire logic                RST_B,
    input  wire logic [NUM_IRQ-1:0]  IRQ_PEND,
    input  wire logic                INSN_DONE,
    input  wire logic                INSN_RETI,
    input  wire logic                INSN_SEI,
    input  wire logic                INSN_CLI,
    input  wire logic                INSN_SLEEP,
    input  wire logic                WAKE_READY,
    input  wire logic [PC_W-1:0]     PC_NEXT,
    input  wire logic [7:0]          STACK_RDATA,
    input  wire logic [ADDR_W-1:0]   DATA_ADDR,
    input  wire logic                DATA_RD,
    input  wire logic                DATA_WR,
    input  wire logic                SHORT_IO,
    input  wire logic [PC_W:0]       PROG_BYTE_ADDR,
    input  wire logic [11:0]         NV_ADDR,
    output logic                     IRQ_ACK,
    output logic [NUM_IRQ-1:0]       IRQ_ACK_ID,
    output logic                     CORE_STALL,
    output logic                     PC_LOAD,
    output logic [PC_W-1:0]          PC_TARGET,
    output logic                     STACK_WE,
    output logic [ADDR_W-1:0]        STACK_ADDR,
    output logic [7:0]               STACK_WDATA,
    output logic [ADDR_W-1:0]        SP_OUT,
    output logic                     GIE_OUT,
    output logic                     SLEEPING,
    output logic [4:0]               DATA_REGION,
    output logic                     IO_HIT,
    output logic                     EXT_RD_STB,
    output logic                     EXT_WR_STB,
    output logic [PC_W-1:0]          PROG_WORD_ADDR,
    output logic                     PROG_BYTE_HI,
    output logic                     PROG_IN_BOOT,
    output logic                     NV_VALID
);
    // ************************************************************
    // state
    // ************************************************************
    cimd_state_t     state_reg, state_next;
    logic [3:0]      cnt_reg, cnt_next;
    logic [7:0]      flags_reg, flags_next;
    logic [ADDR_W-1:0] sp_reg, sp_next;
    logic [PC_W-1:0] pc_save_reg, pc_save_next;
    logic [PC_W-1:0] vec_reg, vec_next;
    logic            hold_reg, hold_next;
    logic [NUM_IRQ-1:0] ack_id_reg, ack_id_next;
    logic [PC_W-1:0] pop_reg, pop_next;

    // ************************************************************
    // priority pick and acceptance
    // ************************************************************
    wire  gie = flags_reg[GIE_BIT];
    wire  any_pend = |IRQ_PEND;
    wire  [NUM_IRQ-1:0] lowest = IRQ_PEND & (~IRQ_PEND + NUM_IRQ'(1));
    logic [PC_W-1:0] vec_idx;
    always_comb begin
        vec_idx = '0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (lowest[i]) begin
                vec_idx = PC_W'(i + 1);
            end
        end
    end
    // vectors are two words apart; slot zero is the reset vector
    wire [PC_W-1:0] vec_addr = {vec_idx[PC_W-2:0], 1'b0};
    // hold_reg blocks service for one instruction after sei or reti
    wire accept = (state_reg == CIMD_RUN) && INSN_DONE && gie && any_pend
                  && !hold_reg && !INSN_CLI && !INSN_SLEEP && !INSN_RETI;

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        flags_next   = flags_reg;
        sp_next      = sp_reg;
        pc_save_next = pc_save_reg;
        vec_next     = vec_reg;
        ack_id_next  = '0;
        pop_next     = pop_reg;
        hold_next    = hold_reg;
        if (INSN_DONE) begin
            hold_next = INSN_SEI || INSN_RETI;
        end
        case (state_reg)
            CIMD_RUN: begin
                if (INSN_CLI) flags_next[GIE_BIT] = 1'b0;
                if (INSN_SEI) flags_next[GIE_BIT] = 1'b1;
                if (accept) begin
                    flags_next[GIE_BIT] = 1'b0;
                    pc_save_next = PC_NEXT;
                    vec_next     = vec_addr;
                    ack_id_next  = lowest;
                    cnt_next     = 4'(ENTRY_CYCLES - 1);
                    state_next   = CIMD_ENTRY;
                end else if (INSN_SLEEP && INSN_DONE) begin
                    state_next = CIMD_SLEEP;
                end else if (INSN_RETI && INSN_DONE) begin
                    cnt_next   = 4'(RET_CYCLES - 1);
                    state_next = CIMD_RET;
                end
            end
            CIMD_SLEEP: begin
                if (any_pend && WAKE_READY) begin
                    cnt_next   = 4'(WAKE_EXTRA - 1);
                    state_next = CIMD_WAKE;
                end
            end
            CIMD_WAKE: begin
                if (cnt_reg == 4'h0) begin
                    if (gie && any_pend) begin
                        flags_next[GIE_BIT] = 1'b0;
                        pc_save_next = PC_NEXT;
                        vec_next     = vec_addr;
                        ack_id_next  = lowest;
                        cnt_next     = 4'(ENTRY_CYCLES - 1);
                        state_next   = CIMD_ENTRY;
                    end else begin
                        state_next = CIMD_RUN;
                    end
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            CIMD_ENTRY: begin
                // push low byte then high byte, sp falls by one each
                if (cnt_reg >= 4'(ENTRY_CYCLES - 2)) begin
                    sp_next = sp_reg - 16'h0001;
                end
                if (cnt_reg == 4'h0) begin
                    cnt_next   = 4'(JMP_CYCLES - 1);
                    state_next = CIMD_JUMP;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            CIMD_JUMP: begin
                if (cnt_reg == 4'h0) begin
                    state_next = CIMD_RUN;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            CIMD_RET: begin
                if (cnt_reg == 4'(RET_CYCLES - 1)) begin
                    sp_next = sp_reg + 16'h0001;
                end else if (cnt_reg == 4'(RET_CYCLES - 2)) begin
                    sp_next = sp_reg + 16'h0001;
                    pop_next[15:8] = STACK_RDATA;
                end else if (cnt_reg == 4'(RET_CYCLES - 3)) begin
                    pop_next[7:0] = STACK_RDATA;
                end
                if (cnt_reg == 4'h0) begin
                    flags_next[GIE_BIT] = 1'b1;
                    state_next = CIMD_RUN;
                end else begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            default: begin
                state_next = CIMD_RUN;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg   <= CIMD_RUN;
            cnt_reg     <= '0;
            flags_reg   <= FLAGS_RESET;
            sp_reg      <= SP_RESET;
            pc_save_reg <= '0;
            vec_reg     <= '0;
            hold_reg    <= 1'b0;
            ack_id_reg  <= '0;
            pop_reg     <= '0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            flags_reg   <= flags_next;
            sp_reg      <= sp_next;
            pc_save_reg <= pc_save_next;
            vec_reg     <= vec_next;
            hold_reg    <= hold_next;
            ack_id_reg  <= ack_id_next;
            pop_reg     <= pop_next;
        end
    end

    // ************************************************************
    // outputs to the core and stack memory
    // ************************************************************
    wire in_entry = state_reg == CIMD_ENTRY;
    wire push_now = in_entry && (cnt_reg >= 4'(ENTRY_CYCLES - 2));
    wire push_hi  = cnt_reg == 4'(ENTRY_CYCLES - 2);
    assign IRQ_ACK     = |ack_id_reg;
    assign IRQ_ACK_ID  = ack_id_reg;
    assign CORE_STALL  = state_reg != CIMD_RUN;
    // vector loads at the end of entry; return target loads at the end of return
    assign PC_LOAD     = (in_entry || state_reg == CIMD_RET) && cnt_reg == 4'h0;
    assign PC_TARGET   = in_entry ? vec_reg : pop_reg;
    assign STACK_WE    = push_now;
    assign STACK_ADDR  = (state_reg == CIMD_RET) ? sp_reg : sp_reg;
    assign STACK_WDATA = push_hi ? pc_save_reg[15:8] : pc_save_reg[7:0];
    assign SP_OUT      = sp_reg;
    assign GIE_OUT     = gie;
    assign SLEEPING    = state_reg == CIMD_SLEEP;

    // ************************************************************
    // memory space decode
    // ************************************************************
    cimd_region_t region;
    cimd_decode u_decode (
        .addr     (DATA_ADDR),
        .short_io (SHORT_IO),
        .region   (region),
        .io_hit   (IO_HIT)
    );
    wire is_ext = region == CIMD_RG_EXT;
    assign DATA_REGION    = region;
    // strobes idle for any internal access
    assign EXT_RD_STB     = is_ext && DATA_RD;
    assign EXT_WR_STB     = is_ext && DATA_WR;
    // byte address into 64K x 16 words, odd byte is the high half
    assign PROG_WORD_ADDR = PROG_BYTE_ADDR[PC_W:1];
    assign PROG_BYTE_HI   = PROG_BYTE_ADDR[0];
    assign PROG_IN_BOOT   = PROG_BYTE_ADDR[PC_W:1] >= BOOT_START;
    assign NV_VALID       = NV_ADDR <= NV_END;
endmodule : cimd_core

// file: cimd_pkg.sv
// package for the interrupt entry sequencer and memory decoder
// assumes a single cpu clock and an asynchronous active-low reset
package cimd_pkg;
    localparam int          NUM_IRQ          = 8;
    localparam int          PC_W             = 16;
    localparam int          ADDR_W           = 16;
    localparam int          ENTRY_CYCLES     = 5;
    localparam int          WAKE_EXTRA       = 5;
    localparam int          JMP_CYCLES       = 3;
    localparam int          RET_CYCLES       = 5;
    localparam logic [15:0] REG_END          = 16'h001F;
    localparam logic [15:0] IO_END           = 16'h005F;
    localparam logic [15:0] EXT_IO_END       = 16'h00FF;
    localparam logic [15:0] SRAM_START       = 16'h0100;
    localparam logic [15:0] SRAM_END         = 16'h20FF;
    localparam logic [11:0] NV_END           = 12'h0FFF;
    localparam logic [15:0] SP_RESET         = 16'h20FF;
    localparam logic [15:0] BOOT_START       = 16'hF000;
    localparam int          IO_SHORT_COUNT   = 64;
    localparam int          GIE_BIT          = 7;
    localparam logic [7:0]  FLAGS_RESET      = 8'h00;

    typedef enum logic [5:0] {
        CIMD_RUN   = 6'b00_0001,
        CIMD_ENTRY = 6'b00_0010,
        CIMD_JUMP  = 6'b00_0100,
        CIMD_RET   = 6'b00_1000,
        CIMD_SLEEP = 6'b01_0000,
        CIMD_WAKE  = 6'b10_0000
    } cimd_state_t;

    typedef enum logic [4:0] {
        CIMD_RG_REGS = 5'b0_0001,
        CIMD_RG_IO   = 5'b0_0010,
        CIMD_RG_EXIO = 5'b0_0100,
        CIMD_RG_SRAM = 5'b0_1000,
        CIMD_RG_EXT  = 5'b1_0000
    } cimd_region_t;
endpackage : cimd_pkg

// file: cimd_decode.sv
// data space decoder: one region per address
// assumes a combinational address from the core
module cimd_decode
    import cimd_pkg::*;
(
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              short_io,
    output cimd_region_t           region,
    output logic                   io_hit
);
    wire is_regs = addr <= REG_END;
    wire is_io   = !is_regs && addr <= IO_END;
    wire is_exio = !is_regs && !is_io && addr <= EXT_IO_END;
    wire is_sram = addr >= SRAM_START && addr <= SRAM_END;

    // exactly one region, contiguous cover of the full space
    assign region = is_regs ? CIMD_RG_REGS :
                    is_io   ? CIMD_RG_IO   :
                    is_exio ? CIMD_RG_EXIO :
                    is_sram ? CIMD_RG_SRAM :
                              CIMD_RG_EXT;
    // short i/o forms reach only the 64 standard locations, never registers or extended i/o
    assign io_hit = short_io ? is_io : 1'b1;
endmodule : cimd_decode

// file: cimd_core_assertions.sv
// concurrent checks on the interrupt sequencer and the memory decoders
// assumes it is bound onto cimd_core; one clock, async active-low reset
module cimd_checker
    import cimd_pkg::*;
(
    input wire logic               REF_CLK,
    input wire logic               RST_B,
    input wire logic [NUM_IRQ-1:0] IRQ_PEND,
    input wire logic               INSN_DONE,
    input wire logic               INSN_RETI,
    input wire logic [PC_W-1:0]    PC_NEXT,
    input wire logic [ADDR_W-1:0]  DATA_ADDR,
    input wire logic               SHORT_IO,
    input wire logic [PC_W:0]      PROG_BYTE_ADDR,
    input wire logic               IRQ_ACK,
    input wire logic [NUM_IRQ-1:0] IRQ_ACK_ID,
    input wire logic               CORE_STALL,
    input wire logic               PC_LOAD,
    input wire logic [PC_W-1:0]    PC_TARGET,
    input wire logic               STACK_WE,
    input wire logic [7:0]         STACK_WDATA,
    input wire logic [ADDR_W-1:0]  SP_OUT,
    input wire logic               GIE_OUT,
    input wire logic [4:0]         DATA_REGION,
    input wire logic               IO_HIT,
    input wire logic               EXT_RD_STB,
    input wire logic               EXT_WR_STB,
    input wire logic [PC_W-1:0]    PROG_WORD_ADDR,
    input wire logic               PROG_BYTE_HI,
    input wire logic               PROG_IN_BOOT
);
    // ****************
    // helper logic
    // ****************
    logic [4:0] exp_region;
    logic       ret_go;
    assign exp_region = (DATA_ADDR <= REG_END) ? 5'h01 : (DATA_ADDR <= IO_END) ? 5'h02 :
                        (DATA_ADDR <= EXT_IO_END) ? 5'h04 : (DATA_ADDR <= SRAM_END) ? 5'h08 : 5'h10;
    assign ret_go = INSN_DONE && INSN_RETI && !CORE_STALL;

    function automatic logic [15:0] vec_of(input logic [7:0] id);
        vec_of = 16'h0000;
        for (int i = 0; i < 8; i++) begin
            if (id[i]) begin
                vec_of = 16'(2 * (i + 1));
            end
        end
    endfunction : vec_of

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    // ****************
    // assertions
    // ****************
    chk_ack_cause: assert property (
        IRQ_ACK |-> $past(GIE_OUT) && ($past(IRQ_PEND) != 8'h00) ##1 !GIE_OUT)
        else $error("ack without enabled pending source or enable not cleared");
    chk_no_ack_off: assert property (
        !GIE_OUT |=> !IRQ_ACK)
        else $error("ack while global enable was clear");
    chk_ack_lowest: assert property (
        IRQ_ACK |-> IRQ_ACK_ID == ($past(IRQ_PEND) & (~$past(IRQ_PEND) + 8'h01)))
        else $error("ack id is not the lowest pending source");
    chk_entry_push: assert property (
        IRQ_ACK |-> STACK_WE && STACK_WDATA == 8'($past(PC_NEXT))
                    ##1 STACK_WE && STACK_WDATA == 8'($past(PC_NEXT, 2) >> 8))
        else $error("return address not pushed low byte then high byte");
    chk_entry_vector: assert property (
        IRQ_ACK |-> !PC_LOAD [*4] ##1 (PC_LOAD && PC_TARGET == vec_of($past(IRQ_ACK_ID, 4))))
        else $error("vector not loaded five cycles after acceptance");
    chk_stall_span: assert property (
        IRQ_ACK |-> CORE_STALL [*8] ##1 !CORE_STALL)
        else $error("entry plus jump stall is not eight cycles");
    chk_sp_push: assert property (
        IRQ_ACK |-> ##2 SP_OUT == $past(SP_OUT, 2) - 16'h0002)
        else $error("stack pointer not lowered by two on entry");
    chk_ret_time: assert property (
        ret_go |-> !PC_LOAD [*5] ##1 PC_LOAD ##1 (GIE_OUT && SP_OUT == $past(SP_OUT, 7) + 16'h0002))
        else $error("return timing, stack pointer or enable wrong");
    chk_decode_map: assert property (
        DATA_REGION == exp_region)
        else $error("data address decoded to the wrong region");
    chk_ext_quiet: assert property (
        DATA_REGION != 5'h10 |-> !EXT_RD_STB && !EXT_WR_STB)
        else $error("external strobe during internal access");
    chk_short_io: assert property (
        IO_HIT == (!SHORT_IO || DATA_REGION == 5'h02))
        else $error("short i/o form reached outside the standard i/o space");
    chk_prog_word: assert property (
        PROG_WORD_ADDR == PROG_BYTE_ADDR[16:1] && PROG_BYTE_HI == PROG_BYTE_ADDR[0]
        && PROG_IN_BOOT == (PROG_BYTE_ADDR[16:1] >= BOOT_START))
        else $error("program byte address split or section wrong");

    cov_entry: cover property (IRQ_ACK);
    cov_return: cover property (ret_go);
    cov_ext: cover property (DATA_REGION == 5'h10 && EXT_RD_STB);
endmodule : cimd_checker

bind cimd_core cimd_checker u_cimd_checker (
    .REF_CLK, .RST_B, .IRQ_PEND, .INSN_DONE, .INSN_RETI, .PC_NEXT, .DATA_ADDR, .PROG_BYTE_ADDR,
    .SHORT_IO, .IO_HIT,
    .IRQ_ACK, .IRQ_ACK_ID, .CORE_STALL, .PC_LOAD, .PC_TARGET, .STACK_WE, .STACK_WDATA, .SP_OUT,
    .GIE_OUT, .DATA_REGION, .EXT_RD_STB, .EXT_WR_STB, .PROG_WORD_ADDR, .PROG_BYTE_HI, .PROG_IN_BOOT
);

// file: cimd_stack_model.sv
// stack memory standing on the core's stack port
// assumes writes on the rising edge and a combinational read
module cimd_stack_model
    import cimd_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wdata,
    output logic      [7:0]        rdata
);
    // only the low address byte is kept: enough for a few nested frames
    logic [7:0] mem_reg [0:255];
    logic       vld_reg [0:255];

    initial begin
        foreach (vld_reg[i]) vld_reg[i] = 1'b0;
    end
    always @(posedge clk) begin
        if (we) begin
            mem_reg[addr[7:0]] <= wdata;
            vld_reg[addr[7:0]] <= 1'b1;
        end
    end
    // unwritten places read back a changing pattern, zero only where the low address byte is FF
    assign rdata = vld_reg[addr[7:0]] ? mem_reg[addr[7:0]] : ~addr[7:0];
endmodule : cimd_stack_model

// file: test_cimd_core.sv
// bench for cimd_core: decode table, interrupt entry and return, sleep, reset
// assumes cimd_stack_model answers the core's stack port
module test_cimd_core
    import cimd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [15:0] addr;
        logic [4:0]  reg_exp;
        logic [16:0] pbyte;
    } cimd_row_t;
    logic        REF_CLK, RST_B, INSN_DONE, INSN_RETI, INSN_SEI, INSN_CLI, INSN_SLEEP, WAKE_READY;
    logic        DATA_RD, DATA_WR, SHORT_IO, IRQ_ACK, CORE_STALL, PC_LOAD, STACK_WE, GIE_OUT, SLEEPING;
    logic        IO_HIT, EXT_RD_STB, EXT_WR_STB, PROG_BYTE_HI, PROG_IN_BOOT, NV_VALID;
    logic [7:0]  IRQ_PEND, IRQ_ACK_ID, STACK_RDATA, STACK_WDATA;
    logic [15:0] PC_NEXT, DATA_ADDR, PC_TARGET, STACK_ADDR, SP_OUT, PROG_WORD_ADDR;
    logic [16:0] PROG_BYTE_ADDR;
    logic [11:0] NV_ADDR;
    logic [4:0]  DATA_REGION;
    logic [3:0]  ev;
    int          bad_count = 0;
    int          samples_checked = 0;
    int          n;
    cimd_row_t   rows [10] = '{
        '{16'h0000, 5'h01, 17'h0_0000}, '{16'h001F, 5'h01, 17'h0_0001},
        '{16'h0020, 5'h02, 17'h0_1FFE}, '{16'h005F, 5'h02, 17'h1_DFFF},
        '{16'h0060, 5'h04, 17'h1_E000}, '{16'h00FF, 5'h04, 17'h1_E001},
        '{16'h0100, 5'h08, 17'h1_FFFE}, '{16'h20FF, 5'h08, 17'h1_FFFF},
        '{16'h2100, 5'h10, 17'h0_8001}, '{16'hFFFF, 5'h10, 17'h1_0000}};

    assign ev = {SLEEPING, ~CORE_STALL, PC_LOAD, IRQ_ACK};

    cimd_core u_cimd_core (
        .REF_CLK, .RST_B, .IRQ_PEND, .INSN_DONE, .INSN_RETI, .INSN_SEI, .INSN_CLI, .INSN_SLEEP,
        .WAKE_READY, .PC_NEXT, .STACK_RDATA, .DATA_ADDR, .DATA_RD, .DATA_WR, .SHORT_IO,
        .PROG_BYTE_ADDR, .NV_ADDR, .IRQ_ACK, .IRQ_ACK_ID, .CORE_STALL, .PC_LOAD, .PC_TARGET,
        .STACK_WE, .STACK_ADDR, .STACK_WDATA, .SP_OUT, .GIE_OUT, .SLEEPING, .DATA_REGION, .IO_HIT,
        .EXT_RD_STB, .EXT_WR_STB, .PROG_WORD_ADDR, .PROG_BYTE_HI, .PROG_IN_BOOT, .NV_VALID);
    cimd_stack_model u_cimd_stack_model (
        .clk(REF_CLK), .we(STACK_WE), .addr(STACK_ADDR), .wdata(STACK_WDATA), .rdata(STACK_RDATA));

    // ****************
    // shared tasks
    // ****************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        if (bad_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    task automatic step;
        @(posedge REF_CLK);
        #1;
    endtask : step
    // kind is {sleep, disable, enable, return}; leaves the bench in the cycle after completion
    task automatic done(input logic [3:0] kind);
        {INSN_SLEEP, INSN_CLI, INSN_SEI, INSN_RETI} = kind;
        INSN_DONE = 1'b1;
        step;
        {INSN_SLEEP, INSN_CLI, INSN_SEI, INSN_RETI} = 4'h0;
        INSN_DONE = 1'b0;
    endtask : done
    // bounded wait; a hang shows up as a wrong cycle count
    task automatic wait_ev(input int k, output int cnt);
        cnt = 0;
        while (ev[k] !== 1'b1 && cnt < 40) begin
            step;
            cnt++;
        end
    endtask : wait_ev

    initial begin
        REF_CLK = 1'b0;
        forever #2 REF_CLK = ~REF_CLK;
    end
    initial begin
        #20000;
        bad_count++;
        tally_and_finish;
    end

    // ****************
    // main sequence
    // ****************
    initial begin
        {INSN_DONE, INSN_RETI, INSN_SEI, INSN_CLI, INSN_SLEEP, WAKE_READY, DATA_RD, DATA_WR} = 8'h00;
        {IRQ_PEND, PC_NEXT, DATA_ADDR, PROG_BYTE_ADDR, NV_ADDR, SHORT_IO} = '0;
        RST_B = 1'b0;
        repeat (16) @(posedge REF_CLK);
        #1;
        RST_B = 1'b1;
        step;
        check(SP_OUT, SP_RESET);
        check(GIE_OUT, 1'b0);
        foreach (rows[i]) begin
            DATA_ADDR = rows[i].addr;
            PROG_BYTE_ADDR = rows[i].pbyte;
            NV_ADDR = rows[i].addr[11:0];
            DATA_RD = i[0];
            DATA_WR = ~i[0];
            SHORT_IO = i[0];
            step;
            check(DATA_REGION, rows[i].reg_exp);
            check({EXT_RD_STB, EXT_WR_STB}, rows[i].reg_exp[4] ? {DATA_RD, DATA_WR} : 2'b00);
            check(PROG_WORD_ADDR, rows[i].pbyte[16:1]);
            check(PROG_BYTE_HI, rows[i].pbyte[0]);
            check(PROG_IN_BOOT, rows[i].pbyte[16:1] >= BOOT_START);
            check(NV_VALID, 1'b1);
            check(IO_HIT, !SHORT_IO || rows[i].reg_exp == 5'h02);
        end
        // enable, then the very next instruction is not interrupted
        done(4'h2);
        IRQ_PEND = 8'h2C;
        PC_NEXT = 16'hBEEF;
        step;
        done(4'h0);
        check(IRQ_ACK, 1'b0);
        repeat (3) begin
            step;
            check(IRQ_ACK, 1'b0);
        end
        done(4'h0);
        check(IRQ_ACK_ID, 8'h04);
        wait_ev(1, n);
        check(n, 4);
        check(PC_TARGET, 16'h0006);
        check(GIE_OUT, 1'b0);
        wait_ev(2, n);
        check(n, 4);
        check(SP_OUT, 16'h20FD);
        IRQ_PEND = 8'h80;
        done(4'h1);
        wait_ev(1, n);
        check(n, 4);
        check(PC_TARGET, 16'hBEEF);
        step;
        check(GIE_OUT, 1'b1);
        check(SP_OUT, SP_RESET);
        wait_ev(2, n);
        done(4'h4);
        check(IRQ_ACK, 1'b0);
        step;
        // enable followed at once by sleep: sleep wins over the pending source
        done(4'h2);
        step;
        done(4'h8);
        check(IRQ_ACK, 1'b0);
        wait_ev(3, n);
        check(SLEEPING, 1'b1);
        repeat (3) step;
        check(IRQ_ACK, 1'b0);
        WAKE_READY = 1'b1;
        wait_ev(0, n);
        check(n >= 5 && n <= 8, 1'b1);
        check(IRQ_ACK_ID, 8'h80);
        wait_ev(1, n);
        check(PC_TARGET, 16'h0010);
        // second reset in the middle of the jump stall
        step;
        RST_B = 1'b0;
        WAKE_READY = 1'b0;
        step;
        check(SP_OUT, SP_RESET);
        check(CORE_STALL, 1'b0);
        check(IRQ_ACK, 1'b0);
        RST_B = 1'b1;
        step;
        check(GIE_OUT, 1'b0);
        tally_and_finish;
    end
endmodule : test_cimd_core
